// *** onoff_defines.svh ***
// offsets, field positions, reset values and timing counts for the on/off sequencer
`ifndef ONOFF_DEFINES_SVH
`define ONOFF_DEFINES_SVH

// ==========================================================================
// command codes and page
`define CMD_RUN_MODE        8'h01
`define CMD_ONOFF_SRC       8'h02
`define CMD_CHAN_OPTIONS    8'hd0
`define PAGE_GLOBAL         8'hff
`define NUM_CHAN            2

// ==========================================================================
// reset values
`define RUN_MODE_RESET      8'h00
`define ONOFF_SRC_RESET     8'h12
`define CHAN_OPT_RESET      16'h0080

// ==========================================================================
// run_mode_control fields
`define RUN_CTRL_HI         7
`define RUN_CTRL_LO         6
`define RUN_MARG_HI         5
`define RUN_MARG_LO         4
`define RUN_FLT_HI          3
`define RUN_FLT_LO          2
`define RUN_WMASK           8'hfc

// ==========================================================================
// onoff_source_config fields
`define SRC_GATED_BIT       4
`define SRC_BUS_BIT         3
`define SRC_PIN_BIT         2
`define SRC_FASTOFF_BIT     0
`define SRC_WMASK           8'h1d
`define SRC_FIXED_ONES      8'h02

// ==========================================================================
// channel_options_config fields
`define OPT_TRACK_BIT       15
`define OPT_CHAIN_BIT       14
`define OPT_PSEL_HI         13
`define OPT_PSEL_LO         12
`define OPT_RES_BIT         10
`define OPT_CONT_BIT        7
`define OPT_RETRIM_BIT      6
`define OPT_DAC_HI          5
`define OPT_DAC_LO          4
`define OPT_DISCH_BIT       2
`define OPT_GAIN_BIT        1
`define OPT_POL_BIT         0
`define OPT_WMASK           16'hfdf7
`define OPT_FIXED_ONES      16'h0008

// ==========================================================================
// timing
`define CLK_PERIOD_NS       20
`define INIT_TIME_US        10
`define INIT_CYCLES         ((`INIT_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// *** onoff_pkg.sv ***
// types shared by the on/off sequencer
package onoff_pkg;

  // ==========================================================================
  // run, margin and DAC mode field codes
  typedef enum logic [1:0] {
    run_off_now  = 2'h0,
    run_seq_off  = 2'h1,
    run_seq_on   = 2'h2,
    run_reserved = 2'h3
  } run_code_t;

  typedef enum logic [1:0] {
    marg_nominal = 2'h0,
    marg_low     = 2'h1,
    marg_high    = 2'h2,
    marg_rsvd    = 2'h3
  } margin_t;

  typedef enum logic [1:0] {
    dac_servo   = 2'h0,
    dac_off     = 2'h1,
    dac_direct  = 2'h2,
    dac_soft    = 2'h3
  } dac_mode_t;

  // ==========================================================================
  // per-channel sequencer state, one-hot
  typedef enum logic [4:0] {
    st_off      = 5'h01,
    st_on_delay = 5'h02,
    st_rising   = 5'h04,
    st_on       = 5'h08,
    st_off_delay= 5'h10
  } seq_state_t;

endpackage : onoff_pkg

// *** init_gate.sv ***
// input-power initialization interval and input-on qualification
`timescale 1ns/1ns
`include "onoff_defines.svh"
module init_gate #(
  parameter int unsigned INIT_CYCLES = `INIT_CYCLES
) (
  input  wire logic clk,        // device clock
  input  wire logic rst,        // async reset, active high
  input  wire logic vin_above,  // input_voltage_sense above input-on threshold
  output logic      init_done,  // initialization interval complete
  output logic      power_ok    // initialized and input above threshold
);

  logic [31:0] cnt_q;

  // ==========================================================================
  // init timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 32'h0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      if (cnt_q >= INIT_CYCLES - 1) begin
        init_done <= 1'b1;
      end
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // ==========================================================================
  // input-on gate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_ok <= 1'b0;
    end else begin
      power_ok <= init_done && vin_above;
    end
  end

endmodule : init_gate

// *** seq_timer.sv ***
// per-channel delay counter, loads a count and flags expiry
`timescale 1ns/1ns
module seq_timer (
  input  wire logic        clk,    // device clock
  input  wire logic        rst,    // async reset, active high
  input  wire logic        load,   // start timer with count
  input  wire logic [15:0] count,  // delay in cycles
  output logic             busy,   // timer running
  output logic             expired // one-cycle pulse at end
);

  logic [15:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= 16'h0;
      busy    <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        // zero delay still costs one cycle so the state machine sees a pulse
        cnt_q   <= count;
        busy    <= (count != 16'h0);
        expired <= (count == 16'h0);
      end else if (busy) begin
        if (cnt_q == 16'h1) begin
          busy    <= 1'b0;
          expired <= 1'b1;
        end
        cnt_q <= cnt_q - 16'h1;
      end
    end
  end

endmodule : seq_timer

// *** onoff_seq.sv ***
// two-channel on/off, margin and channel option control behind the command port
//
// Functional notes
// - run and source registers accept global page writes, updating every channel
// - run field: 00 off now, 10 sequence on, 01 sequence off; bits 1:0 zero
// - margin field selects nominal, low or high, also while sequencing off
// - fault field 01 ignores faults when margining, 10 keeps responding
// - bus acceptance clear: run field ignored, margin still applies
// - no sequencing until initialized and input above the input-on threshold
// - after initialization the turn-on delay timer starts
// - gated bit clear: power up with sequencing regardless of pin or bus
// - gated bit set: power up only when enabled sources command; 00 never
// - pin-required bit needs selected pin; with bus bit, run command also
// - pin quick-off bit: 0 uses turn-off delay, 1 stops at once
// - tracking slave disables undervoltage detection during turn-off delay
// - pin-select 00 first run pin, 01 second run pin, others reserved
// - supervisor step bit selects 4mV or 8mV per LSB
// - servo mode: continuous trim bit keeps servoing, else stops at target
// - retrim-on-warning re-servos to nominal at high or low warn level
// - DAC usage after rise: servo, disconnected, direct, soft-connect
// - discharge bit 0 fast pull-down always; 1 weak on soft stop
// - DAC range bit 1.38V or 2.65V; polarity bit inverting or not
// - chained-start slave waits for its control input before starting
// - chained slave retries with pin low; bus off-on clears faulted-off
`timescale 1ns/1ns
`include "onoff_defines.svh"
module onoff_seq (
  input  wire logic        clk,              // device clock, 50 MHz
  input  wire logic        rst,              // async reset, active high
  input  wire logic        cmd_wr,           // command write strobe
  input  wire logic        cmd_rd,           // command read strobe
  input  wire logic [7:0]  cmd_code,         // command code
  input  wire logic [7:0]  cmd_page,         // page, ff is global
  input  wire logic [15:0] cmd_wdata,        // write data, bytes in low bits
  output logic      [15:0] cmd_rdata,        // read data
  output logic             cmd_rvalid,       // read data valid pulse
  input  wire logic        input_voltage_sense, // input above input-on threshold
  input  wire logic        first_run_pin,    // first control pin, active high
  input  wire logic        second_run_pin,   // second control pin, active high
  input  wire logic [1:0]  fault_off,        // channel faulted off
  input  wire logic [1:0]  retry_req,        // fault retry request
  input  wire logic [1:0]  at_high_warn,     // output at high_warn_level
  input  wire logic [1:0]  at_low_warn,      // output at low_warn_level
  input  wire logic [15:0] on_delay,         // turn-on delay cycles
  input  wire logic [15:0] rise_time,        // turn-on rise cycles
  input  wire logic [15:0] off_delay,        // turn-off delay cycles
  output logic      [1:0]  output_enable,    // channel enable output
  output logic      [1:0]  fast_pulldown,    // fast enable pull-down active
  output logic      [1:0]  weak_pulldown,    // weak limited pull-down active
  output logic      [3:0]  margin_sel,       // per-channel margin code
  output logic      [1:0]  ignore_faults,    // margin ignoring faults
  output logic      [1:0]  uv_detect_en,     // undervoltage detection enable
  output logic      [1:0]  servo_active,     // trim servo running
  output logic      [1:0]  dac_connect,      // trim DAC connected
  output logic      [1:0]  dac_soft,         // soft-connect in progress mode
  output logic      [1:0]  dac_boot_value,   // direct mode uses boot value
  output logic      [1:0]  dac_wide_range,   // 2.65V range selected
  output logic      [1:0]  dac_noninvert,    // non-inverting trim
  output logic      [1:0]  sup_coarse        // 8mV step supervisor
);

  logic [7:0]  run_q  [`NUM_CHAN];
  logic [7:0]  src_q  [`NUM_CHAN];
  logic [15:0] opt_q  [`NUM_CHAN];
  logic        power_ok;

  init_gate u_init (
    .clk       (clk),
    .rst       (rst),
    .vin_above (input_voltage_sense),
    .init_done (),
    .power_ok  (power_ok)
  );

  // ==========================================================================
  // read port
  // page ff reads zero, as the two channels need not agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_rdata  <= 16'h0;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_rd;
      cmd_rdata  <= 16'h0;
      if (cmd_rd && cmd_page[7:1] == 7'h0) begin
        unique case (cmd_code)
          `CMD_RUN_MODE:     cmd_rdata <= {8'h0, run_q[cmd_page[0]] & `RUN_WMASK};
          `CMD_ONOFF_SRC:    cmd_rdata <= {8'h0, src_q[cmd_page[0]]};
          `CMD_CHAN_OPTIONS: cmd_rdata <= opt_q[cmd_page[0]];
          default:           cmd_rdata <= 16'h0;
        endcase
      end
    end
  end

  // ==========================================================================
  // per-channel logic
  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CHAN; ch++) begin : g_ch
      logic                 sel_wr;
      logic                 opt_wr;
      logic                 pin_q;
      logic                 pin_lvl;
      logic                 bus_on;
      logic                 want_on;
      logic                 chain_ok;
      logic                 prev_bus_on_q;
      logic                 clear_fault_q;
      logic                 servo_done_q;
      logic                 soft_stop_q;
      logic                 t_load;
      logic [15:0]          t_count;
      logic                 t_busy;
      logic                 t_exp;
      onoff_pkg::seq_state_t st_q;
      onoff_pkg::dac_mode_t  dmode;

      seq_timer u_tmr (
        .clk     (clk),
        .rst     (rst),
        .load    (t_load),
        .count   (t_count),
        .busy    (t_busy),
        .expired (t_exp)
      );

      assign sel_wr = cmd_wr && (cmd_page == `PAGE_GLOBAL || cmd_page == 8'(ch));
      assign opt_wr = cmd_wr && cmd_page == 8'(ch) && cmd_code == `CMD_CHAN_OPTIONS;
      assign dmode  = onoff_pkg::dac_mode_t'(opt_q[ch][`OPT_DAC_HI:`OPT_DAC_LO]);

      // ----------------------------------------------------------------------
      // registers
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          run_q[ch] <= `RUN_MODE_RESET;
          src_q[ch] <= `ONOFF_SRC_RESET;
          opt_q[ch] <= `CHAN_OPT_RESET;
        end else begin
          if (sel_wr && cmd_code == `CMD_RUN_MODE) begin
            run_q[ch] <= cmd_wdata[7:0] & `RUN_WMASK;
          end
          if (sel_wr && cmd_code == `CMD_ONOFF_SRC) begin
            src_q[ch] <= (cmd_wdata[7:0] & `SRC_WMASK) | `SRC_FIXED_ONES;
          end
          if (opt_wr) begin
            opt_q[ch] <= (cmd_wdata & `OPT_WMASK) | `OPT_FIXED_ONES;
          end
        end
      end

      // selected pin, reserved select codes read as deasserted
      always_comb begin
        unique case (opt_q[ch][`OPT_PSEL_HI:`OPT_PSEL_LO])
          2'h0:    pin_lvl = first_run_pin;
          2'h1:    pin_lvl = second_run_pin;
          default: pin_lvl = 1'b0;
        endcase
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pin_q <= 1'b0;
        end else begin
          pin_q <= pin_lvl;
        end
      end

      // host keeps the minimum off interval between bus off and on
      assign bus_on = run_q[ch][`RUN_CTRL_HI:`RUN_CTRL_LO] == 2'(onoff_pkg::run_seq_on);

      // combine enabled sources
      always_comb begin
        if (!src_q[ch][`SRC_GATED_BIT]) begin
          want_on = 1'b1;
        end else if (!src_q[ch][`SRC_BUS_BIT] && !src_q[ch][`SRC_PIN_BIT]) begin
          want_on = 1'b0;
        end else begin
          want_on = (!src_q[ch][`SRC_PIN_BIT] || pin_q) &&
                    (!src_q[ch][`SRC_BUS_BIT] || bus_on);
        end
      end

      // chained start waits for the previous supply's good level
      assign chain_ok = !opt_q[ch][`OPT_CHAIN_BIT] || pin_q;

      // bus off then on clears a faulted-off chained slave
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          prev_bus_on_q <= 1'b0;
          clear_fault_q <= 1'b0;
        end else begin
          prev_bus_on_q <= bus_on;
          clear_fault_q <= opt_q[ch][`OPT_CHAIN_BIT] && bus_on && !prev_bus_on_q;
        end
      end

      // ----------------------------------------------------------------------
      // sequencer
      always_comb begin
        t_load  = 1'b0;
        t_count = 16'h0;
        unique case (st_q)
          onoff_pkg::st_off: begin
            t_load  = power_ok && want_on && (!fault_off[ch] || clear_fault_q) &&
                      (chain_ok || retry_req[ch]);
            t_count = on_delay;
          end
          onoff_pkg::st_on_delay: begin
            t_load  = t_exp;
            t_count = rise_time;
          end
          onoff_pkg::st_rising, onoff_pkg::st_on: begin
            t_load  = (st_q == onoff_pkg::st_on || !t_busy) && !want_on &&
                      !(src_q[ch][`SRC_FASTOFF_BIT] && !pin_q && src_q[ch][`SRC_PIN_BIT]);
            t_count = off_delay;
          end
          onoff_pkg::st_off_delay: begin
            t_load  = 1'b0;
            t_count = 16'h0;
          end
        endcase
      end

      // a fault or off-now leaves at once; a soft stop waits out off_delay
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st_q        <= onoff_pkg::st_off;
          soft_stop_q <= 1'b0;
        end else begin
          unique case (st_q)
            onoff_pkg::st_off: begin
              if (t_load) begin
                st_q <= onoff_pkg::st_on_delay;
              end
            end
            onoff_pkg::st_on_delay: begin
              if (fault_off[ch] || !power_ok) begin
                st_q <= onoff_pkg::st_off;
              end else if (t_exp) begin
                st_q <= onoff_pkg::st_rising;
              end
            end
            onoff_pkg::st_rising, onoff_pkg::st_on: begin
              if (fault_off[ch]) begin
                st_q        <= onoff_pkg::st_off;
                soft_stop_q <= 1'b0;
              end else if (src_q[ch][`SRC_BUS_BIT] && src_q[ch][`SRC_GATED_BIT] &&
                           run_q[ch][`RUN_CTRL_HI:`RUN_CTRL_LO] ==
                           2'(onoff_pkg::run_off_now)) begin
                st_q        <= onoff_pkg::st_off;
                soft_stop_q <= 1'b1;
              end else if (!want_on && src_q[ch][`SRC_FASTOFF_BIT] &&
                           src_q[ch][`SRC_PIN_BIT] && !pin_q) begin
                st_q        <= onoff_pkg::st_off;
                soft_stop_q <= 1'b1;
              end else if (t_load) begin
                st_q <= onoff_pkg::st_off_delay;
              end else if (st_q == onoff_pkg::st_rising && !t_busy) begin
                st_q <= onoff_pkg::st_on;
              end
            end
            onoff_pkg::st_off_delay: begin
              if (fault_off[ch]) begin
                st_q        <= onoff_pkg::st_off;
                soft_stop_q <= 1'b0;
              end else if (t_exp || !t_busy) begin
                st_q        <= onoff_pkg::st_off;
                soft_stop_q <= 1'b1;
              end
            end
          endcase
        end
      end

      // ----------------------------------------------------------------------
      // servo: one pass to target unless continuous or warn retrim
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          servo_done_q <= 1'b0;
        end else if (st_q != onoff_pkg::st_on || opt_wr || sel_wr) begin
          servo_done_q <= 1'b0;
        end else if (!opt_q[ch][`OPT_CONT_BIT]) begin
          if (opt_q[ch][`OPT_RETRIM_BIT] && (at_high_warn[ch] || at_low_warn[ch])) begin
            servo_done_q <= 1'b0;
          end else begin
            servo_done_q <= 1'b1;
          end
        end
      end

      // ----------------------------------------------------------------------
      // outputs
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          output_enable[ch]      <= 1'b0;
          fast_pulldown[ch]      <= 1'b1;
          weak_pulldown[ch]      <= 1'b0;
          margin_sel[2*ch +: 2]  <= 2'h0;
          ignore_faults[ch]      <= 1'b0;
          uv_detect_en[ch]       <= 1'b0;
          servo_active[ch]       <= 1'b0;
          dac_connect[ch]        <= 1'b0;
          dac_soft[ch]           <= 1'b0;
          dac_boot_value[ch]     <= 1'b1;
          dac_wide_range[ch]     <= 1'b0;
          dac_noninvert[ch]      <= 1'b0;
          sup_coarse[ch]         <= 1'b0;
        end else begin
          output_enable[ch] <= st_q inside {onoff_pkg::st_rising, onoff_pkg::st_on,
                                            onoff_pkg::st_off_delay};
          if (st_q inside {onoff_pkg::st_off, onoff_pkg::st_on_delay}) begin
            fast_pulldown[ch] <= !(opt_q[ch][`OPT_DISCH_BIT] && soft_stop_q);
            weak_pulldown[ch] <= opt_q[ch][`OPT_DISCH_BIT] && soft_stop_q;
          end else begin
            fast_pulldown[ch] <= 1'b0;
            weak_pulldown[ch] <= 1'b0;
          end
          margin_sel[2*ch +: 2] <= run_q[ch][`RUN_MARG_HI:`RUN_MARG_LO];
          ignore_faults[ch] <= run_q[ch][`RUN_MARG_HI:`RUN_MARG_LO] != 2'h0 &&
                               run_q[ch][`RUN_FLT_HI:`RUN_FLT_LO] == 2'h1;
          uv_detect_en[ch] <= st_q == onoff_pkg::st_on ||
                              (st_q == onoff_pkg::st_off_delay &&
                               !opt_q[ch][`OPT_TRACK_BIT]);
          servo_active[ch] <= st_q == onoff_pkg::st_on && dmode == onoff_pkg::dac_servo &&
                              (opt_q[ch][`OPT_CONT_BIT] || !servo_done_q);
          dac_connect[ch] <= st_q == onoff_pkg::st_on && dmode != onoff_pkg::dac_off;
          dac_soft[ch] <= dmode inside {onoff_pkg::dac_servo, onoff_pkg::dac_soft};
          if (opt_wr) begin
            dac_boot_value[ch] <= 1'b0;
          end
          dac_wide_range[ch] <= opt_q[ch][`OPT_GAIN_BIT];
          dac_noninvert[ch]  <= opt_q[ch][`OPT_POL_BIT];
          sup_coarse[ch]     <= opt_q[ch][`OPT_RES_BIT];
        end
      end
    end
  endgenerate

endmodule : onoff_seq

// *** onoff_seq_sva.sv ***
// concurrent checks on the on/off sequencer ports
`timescale 1ns/1ns
`include "onoff_defines.svh"
module onoff_seq_sva (
  input wire logic        clk,           // clock
  input wire logic        rst,           // async reset
  input wire logic        cmd_wr,        // write strobe
  input wire logic        cmd_rd,        // read strobe
  input wire logic [7:0]  cmd_code,      // command code
  input wire logic [7:0]  cmd_page,      // page
  input wire logic [15:0] cmd_wdata,     // write data
  input wire logic [15:0] cmd_rdata,     // read data
  input wire logic        cmd_rvalid,    // read valid
  input wire logic [1:0]  fault_off,     // faulted off
  input wire logic [1:0]  output_enable, // enable out
  input wire logic [1:0]  fast_pulldown, // fast pull-down
  input wire logic [1:0]  weak_pulldown, // weak pull-down
  input wire logic [3:0]  margin_sel,    // margin codes
  input wire logic [1:0]  ignore_faults  // margin ignores faults
);
  localparam int INIT = `INIT_CYCLES;
  logic [9:0] up_q;

  // ====================
  // cycles since reset release, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      up_q <= 10'h0;
    else if (up_q != 10'h3ff)
      up_q <= up_q + 10'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_read_answer: assert property (cmd_rd |=> cmd_rvalid)
    else $error("read strobe not answered next cycle");
  a_rdata_idle: assert property (!cmd_rvalid |-> cmd_rdata == 16'h0)
    else $error("read data not zero outside answer");
  a_init_hold: assert property ($rose(|output_enable) |-> up_q >= INIT)
    else $error("output enabled before initialization");
  a_global_write: assert property (cmd_wr && cmd_code == `CMD_RUN_MODE &&
    cmd_page == `PAGE_GLOBAL |-> ##2 margin_sel == {2{$past(cmd_wdata[5:4], 2)}})
    else $error("global run write did not reach both channels");
  a_on_no_pull: assert property (output_enable[0] |-> !fast_pulldown[0] && !weak_pulldown[0])
    else $error("pull-down active while enabled");
  a_pull_onehot: assert property ((fast_pulldown & weak_pulldown) == 2'h0)
    else $error("fast and weak pull-down together");
  a_fault_off: assert property (fault_off[0] |-> ##[1:3] !output_enable[0] && fast_pulldown[0])
    else $error("fault did not force fast off");
  a_ignore_marg: assert property (ignore_faults[0] |-> margin_sel[1:0] != 2'h0)
    else $error("faults ignored at nominal");
  c_power_on: cover property ($rose(output_enable[0]));
  c_fault: cover property (fault_off[0]);
  c_margin: cover property (|ignore_faults);
endmodule : onoff_seq_sva

bind onoff_seq onoff_seq_sva u_sva (
  .clk, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_page, .cmd_wdata, .cmd_rdata, .cmd_rvalid,
  .fault_off, .output_enable, .fast_pulldown, .weak_pulldown, .margin_sel, .ignore_faults
);

// *** upstream_supply.sv ***
// upstream supply whose power-good output feeds a run pin
`timescale 1ns/1ns
module upstream_supply #(
  parameter int RISE = 5
) (
  input  wire logic clk,    // clock
  input  wire logic enable, // supply commanded on
  output logic      pg      // power-good, active high
);
  int cnt = 0;

  // power-good drops at once when the supply is switched off
  always @(posedge clk) begin
    cnt <= enable ? ((cnt < RISE) ? cnt + 1 : cnt) : 0;
    pg <= enable && (cnt == RISE);
  end
endmodule : upstream_supply

// *** channel_onoff_sequencing_control_test.sv ***
// self-checking bench for the two-channel on/off sequencer
`timescale 1ns/1ns
`include "onoff_defines.svh"
module channel_onoff_sequencing_control_test;
  logic        clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, cmd_rd = 1'b0, cmd_rvalid;
  logic        input_voltage_sense = 1'b0;
  logic [7:0]  cmd_code = 8'h0, cmd_page = 8'h0;
  logic [7:0]  codes [3] = '{`CMD_RUN_MODE, `CMD_ONOFF_SRC, `CMD_CHAN_OPTIONS};
  logic [15:0] cmd_wdata = 16'h0, on_delay = 16'h2, rise_time = 16'h2, off_delay = 16'h40;
  logic [15:0] cmd_rdata, d;
  logic [1:0]  fault_off = 2'h0, pg_req = 2'h0, run_pins, output_enable, fast_pulldown;
  logic [1:0]  ignore_faults, m, f, bv, dw, dn, sc;
  logic [3:0]  margin_sel;
  int          fails = 0, total_checks = 0, cyc = 0;

  initial forever #10 clk = ~clk;

  upstream_supply u_pg [1:0] (.clk(clk), .enable(pg_req), .pg(run_pins));
  onoff_seq u_dut (
    .clk, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_page, .cmd_wdata, .cmd_rdata, .cmd_rvalid,
    .input_voltage_sense, .first_run_pin(run_pins[0]), .second_run_pin(run_pins[1]),
    .fault_off, .retry_req(2'h0), .at_high_warn(2'h0), .at_low_warn(2'h0), .on_delay,
    .rise_time, .off_delay, .output_enable, .fast_pulldown, .weak_pulldown(), .margin_sel,
    .ignore_faults, .uv_detect_en(), .servo_active(), .dac_connect(), .dac_soft(),
    .dac_boot_value(bv), .dac_wide_range(dw), .dac_noninvert(dn), .sup_coarse(sc)
  );

  // ====================
  // tasks and expectations
  function automatic logic [15:0] exp_reg(input logic [7:0] c, input logic [15:0] v);
    case (c)
      `CMD_RUN_MODE:  return v & `RUN_WMASK;
      `CMD_ONOFF_SRC: return (v & `SRC_WMASK) | `SRC_FIXED_ONES;
      default:        return (v & `OPT_WMASK) | `OPT_FIXED_ONES;
    endcase
  endfunction : exp_reg

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] v);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_page <= p;
    cmd_wdata <= v;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= c;
    cmd_page <= p;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1 chk(cmd_rvalid ? cmd_rdata : 16'hdead, e);
  endtask : rd

  task automatic wait_oe(input logic [1:0] v, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (output_enable !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(output_enable, v);
  endtask : wait_oe

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // hang guard, well above the fewer than a thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      report_and_stop;
    end
  end

  // ====================
  // main sequence
  initial begin
    void'($urandom(88));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`CMD_RUN_MODE, 8'h00, `RUN_MODE_RESET);
    rd(`CMD_ONOFF_SRC, 8'h01, `ONOFF_SRC_RESET);
    rd(`CMD_CHAN_OPTIONS, 8'h00, `CHAN_OPT_RESET);
    rd(8'h03, 8'h00, 16'h0);
    rd(`CMD_RUN_MODE, `PAGE_GLOBAL, 16'h0);
    chk(bv, 2'h3);
    $display("test reset_values done");
    wr(`CMD_ONOFF_SRC, `PAGE_GLOBAL, 16'h18);
    wr(`CMD_RUN_MODE, `PAGE_GLOBAL, 16'h80);
    repeat (560) @(negedge clk);
    chk(output_enable, 2'h0);
    @(posedge clk);
    input_voltage_sense <= 1'b1;
    wait_oe(2'h3, 100);
    $display("test startup done");
    wr(`CMD_RUN_MODE, `PAGE_GLOBAL, 16'h00);
    wait_oe(2'h0, 4);
    chk(fast_pulldown, 2'h3);
    repeat (50) @(posedge clk);
    wr(`CMD_RUN_MODE, `PAGE_GLOBAL, 16'h80);
    wait_oe(2'h3, 20);
    wr(`CMD_RUN_MODE, `PAGE_GLOBAL, 16'h40);
    repeat (30) @(posedge clk);
    wait_oe(2'h3, 0);
    wait_oe(2'h0, 60);
    $display("test bus_off done");
    wr(`CMD_CHAN_OPTIONS, 8'h01, 16'h1080);
    wr(`CMD_ONOFF_SRC, `PAGE_GLOBAL, 16'h15);
    chk(bv, 2'h1);
    pg_req <= 2'h1;
    wait_oe(2'h1, 40);
    @(posedge clk);
    pg_req <= 2'h0;
    wait_oe(2'h0, 5);
    @(posedge clk);
    fault_off <= 2'h3;
    repeat (4) @(posedge clk);
    fault_off <= 2'h0;
    $display("test run_pins done");
    repeat (4) begin
      m = 2'($urandom_range(2));
      f = 2'($urandom_range(2, 1));
      wr(`CMD_RUN_MODE, `PAGE_GLOBAL, {8'h0, 2'($urandom_range(2)), m, f, 2'h0});
      repeat (3) @(negedge clk);
      chk(margin_sel, {m, m});
      chk(ignore_faults, (m != 2'h0 && f == 2'h1) ? 2'h3 : 2'h0);
      chk(output_enable, 2'h0);
    end
    $display("test margin done");
    repeat (2) foreach (codes[i]) begin
      d = 16'($urandom);
      wr(codes[i], (i == 2) ? 8'h00 : `PAGE_GLOBAL, d);
      rd(codes[i], (i == 2) ? 8'h00 : 8'h01, exp_reg(codes[i], d));
      if (i == 2) chk({sc[0], dn[0], dw[0]}, {d[10], d[0], d[1]});
    end
    $display("test register_masks done");
    report_and_stop;
  end
endmodule : channel_onoff_sequencing_control_test
